// ### logic/bbt_engine.sv
`timescale 1ns/1ns
// Functional notes
// - read bursts: aligned 16-byte block, four words
// - order from critical word and sub-block select
// - start at critical word, sequential wraps upward
// - sub-block order is start XOR step
// - hold address until edge after ready
// - address valid while address is presented
// - fetch flag only for instruction bursts
// - burst indicator with every burst address
// - first strobe first address, last strobe last
// - read sampling starts two clocks after ready
// - capture word on each read-valid sample
// - burst write only for full block entry
// - burst write starts at word zero
// - write, burst, valid asserted during addresses
// - hold write word until write ready sampled
// - present address without waiting for ready
// - write indicator low reads, high writes
module bbt_engine (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire bbt_pkg::bbt_req_type req_in,
	output logic req_ready_out,
	input wire logic wr_valid_in,
	input wire logic [bbt_pkg::DATA_W-1:0] wr_word_in,
	output logic wr_ready_out,
	output bbt_pkg::bbt_bus_type bus_ctl_out,
	output logic [bbt_pkg::DATA_W-1:0] write_data_bus_out,
	input wire logic address_accept_ready_in,
	input wire logic subblock_order_select_in,
	input wire logic [bbt_pkg::DATA_W-1:0] read_data_bus_in,
	input wire logic read_data_valid_in,
	input wire logic read_bus_error_in,
	input wire logic write_data_ready_in,
	input wire logic write_bus_error_in,
	output bbt_pkg::bbt_ret_type rd_ret_out,
	output logic wr_err_out,
	output logic busy_out
);
	import bbt_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		bbt_state_type state;
		logic busy;
		logic req_ready;
		logic is_write;
		logic is_burst;
		logic instr;
		logic sub_order;
		logic [BLOCK_W-1:0] block;
		logic [BE_W-1:0] byte_en;
		logic [WORDS-1:0] pend_mask;
		logic [1:0] start_word;
		logic [1:0] cur_word;
		logic [1:0] addr_cnt;
		logic addr_done;
		logic [1:0] data_cnt;
		logic data_done;
		logic wd_need;
		logic rd_armed;
		logic [1:0] rd_delay;
		logic rd_open;
		logic wr_err_watch;
		logic wr_err;
		bbt_bus_type bus;
		logic [DATA_W-1:0] wdata;
		bbt_ret_type rd_ret;
		logic [BUF_DEPTH-1:0][DATA_W-1:0] mem;
		logic rd_ptr;
		logic wr_ptr;
		logic [1:0] buf_count;
		logic buf_ready;
	} bbt_engine_state_type;

	bbt_engine_state_type s;
	bbt_engine_state_type next_s;
	logic launch;
	logic issue;
	logic [1:0] issue_word;
	logic pop;
	logic push;
	logic [WORDS-1:0] remain;

	function automatic logic [1:0] lowest_word(input logic [WORDS-1:0] mask);
		logic [1:0] w;
		w = WORD_FIRST;
		for (int i = WORDS - 1; i >= 0; i--) begin
			if (mask[i]) begin
				w = 2'(i);
			end
		end
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		launch = 1'b0;
		issue = 1'b0;
		issue_word = WORD_FIRST;
		pop = 1'b0;
		remain = MASK_NONE;
		push = wr_valid_in && s.buf_ready;
		next_s.rd_ret.valid = 1'b0;
		next_s.rd_ret.err = 1'b0;
		next_s.wr_err = 1'b0;
		// Error for a write word is presented one clock after its ready
		if (s.wr_err_watch) begin
			next_s.wr_err = write_bus_error_in;
			next_s.wr_err_watch = 1'b0;
		end
		case (s.state)
			BBT_ST_IDLE: begin
				// A write waits until its first word sits in the buffer
				if (req_valid_in && s.req_ready && (!req_in.is_write || s.buf_count != BUF_EMPTY)) begin
					launch = 1'b1;
					next_s.state = BBT_ST_RUN;
					next_s.is_write = req_in.is_write;
					next_s.is_burst = !req_in.is_write || req_in.word_mask == MASK_FULL;
					next_s.instr = !req_in.is_write && req_in.instr;
					next_s.sub_order = !req_in.is_write && subblock_order_select_in;
					next_s.block = req_in.block;
					next_s.byte_en = req_in.byte_en;
					next_s.pend_mask = req_in.word_mask;
					if (!req_in.is_write) begin
						next_s.start_word = req_in.crit_word;
					end else if (req_in.word_mask == MASK_FULL) begin
						next_s.start_word = WORD_FIRST;
					end else begin
						next_s.start_word = lowest_word(req_in.word_mask);
					end
					issue = 1'b1;
					issue_word = next_s.start_word;
				end
			end
			BBT_ST_RUN: begin
				// Address phase
				if (s.bus.address_valid && address_accept_ready_in) begin
					if (!s.is_write && s.addr_cnt == WORD_FIRST) begin
						next_s.rd_armed = 1'b1;
						next_s.rd_delay = RD_GAP;
					end
					if (s.is_burst && s.addr_cnt != WORD_LAST) begin
						next_s.addr_cnt = 2'(s.addr_cnt + 2'h1);
						next_s.bus.bus_word_address = {s.block,
							bbt_order(s.start_word, next_s.addr_cnt, s.sub_order)};
						next_s.bus.first_of_burst_strobe = 1'b0;
						next_s.bus.last_of_burst_strobe = next_s.addr_cnt == WORD_LAST;
					end else begin
						next_s.addr_done = 1'b1;
						next_s.bus.address_valid = 1'b0;
						next_s.bus.burst_indicator = 1'b0;
						next_s.bus.first_of_burst_strobe = 1'b0;
						next_s.bus.last_of_burst_strobe = 1'b0;
						next_s.bus.instruction_fetch_flag = 1'b0;
					end
				end
				// Read data window opens on the second edge after the first accept
				if (s.rd_armed) begin
					if (s.rd_delay == RD_GAP - RD_GAP) begin
						next_s.rd_open = 1'b1;
						next_s.rd_armed = 1'b0;
					end else begin
						next_s.rd_delay = 2'(s.rd_delay - 2'h1);
					end
				end
				if (s.rd_open && read_data_valid_in) begin
					next_s.rd_ret.valid = 1'b1;
					next_s.rd_ret.err = read_bus_error_in;
					next_s.rd_ret.data = read_data_bus_in;
					next_s.rd_ret.index = bbt_order(s.start_word, s.data_cnt, s.sub_order);
					if (s.data_cnt == WORD_LAST) begin
						next_s.data_done = 1'b1;
						next_s.rd_open = 1'b0;
					end else begin
						next_s.data_cnt = 2'(s.data_cnt + 2'h1);
					end
				end
				// Write data: a starved buffer stalls the word rather than repeat one
				if (s.is_write && s.wd_need && s.buf_count != BUF_EMPTY) begin
					next_s.wdata = s.mem[s.rd_ptr];
					next_s.wd_need = 1'b0;
					pop = 1'b1;
				end else if (s.is_write && !s.data_done && !s.wd_need && write_data_ready_in) begin
					next_s.wr_err_watch = 1'b1;
					if (s.is_burst && s.data_cnt != WORD_LAST) begin
						next_s.data_cnt = 2'(s.data_cnt + 2'h1);
						if (s.buf_count != BUF_EMPTY) begin
							next_s.wdata = s.mem[s.rd_ptr];
							pop = 1'b1;
						end else begin
							next_s.wd_need = 1'b1;
						end
					end else begin
						next_s.data_done = 1'b1;
					end
				end
				// Completion, or the next single write of a partial entry
				if (next_s.addr_done && next_s.data_done) begin
					remain = s.pend_mask;
					if (s.is_write && !s.is_burst) begin
						remain[s.cur_word] = 1'b0;
					end
					next_s.pend_mask = remain;
					if (s.is_write && !s.is_burst && remain != MASK_NONE) begin
						if (s.buf_count != BUF_EMPTY && !pop) begin
							issue = 1'b1;
							issue_word = lowest_word(remain);
						end
					end else begin
						next_s.state = BBT_ST_IDLE;
						next_s.pend_mask = MASK_NONE;
					end
				end
			end
			default: begin
				next_s.state = BBT_ST_IDLE;
			end
		endcase
		// Present an address at once, whatever the ready input shows
		if (issue) begin
			next_s.cur_word = issue_word;
			next_s.addr_cnt = WORD_FIRST;
			next_s.data_cnt = WORD_FIRST;
			next_s.addr_done = 1'b0;
			next_s.data_done = !next_s.is_write && !next_s.is_burst;
			next_s.wd_need = 1'b0;
			next_s.rd_armed = 1'b0;
			next_s.rd_open = 1'b0;
			next_s.bus.bus_word_address = {next_s.block, issue_word};
			next_s.bus.bus_byte_enables = next_s.is_burst ? BYTES_ALL : next_s.byte_en;
			next_s.bus.address_valid = 1'b1;
			next_s.bus.burst_indicator = next_s.is_burst;
			next_s.bus.first_of_burst_strobe = next_s.is_burst;
			next_s.bus.last_of_burst_strobe = 1'b0;
			next_s.bus.write_indicator = next_s.is_write;
			next_s.bus.instruction_fetch_flag = next_s.instr;
			if (next_s.is_write) begin
				next_s.wdata = s.mem[s.rd_ptr];
				pop = 1'b1;
			end
		end
		// Two-entry write word buffer
		if (pop) begin
			next_s.rd_ptr = ~s.rd_ptr;
		end
		if (push) begin
			next_s.mem[s.wr_ptr] = wr_word_in;
			next_s.wr_ptr = ~s.wr_ptr;
		end
		if (push && !pop) begin
			next_s.buf_count = 2'(s.buf_count + 2'h1);
		end else if (pop && !push) begin
			next_s.buf_count = 2'(s.buf_count - 2'h1);
		end
		next_s.buf_ready = next_s.buf_count != BUF_FULL;
		next_s.req_ready = next_s.state == BBT_ST_IDLE;
		next_s.busy = next_s.state == BBT_ST_RUN;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.state <= BBT_ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign req_ready_out = s.req_ready;
	assign wr_ready_out = s.buf_ready;
	assign bus_ctl_out = s.bus;
	assign write_data_bus_out = s.wdata;
	assign rd_ret_out = s.rd_ret;
	assign wr_err_out = s.wr_err;
	assign busy_out = s.busy;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	a_addr_hold_wait: assert property (
		(s.bus.address_valid && !address_accept_ready_in)
		|=> s.bus.address_valid && $stable(s.bus.bus_word_address) && $stable(s.bus.bus_byte_enables))
		else $error("address moved before ready was sampled");

	a_addr_valid_run: assert property (
		(s.state == BBT_ST_RUN && !s.addr_done) |-> s.bus.address_valid)
		else $error("address valid low while address presented");

	a_burst_flag_addr: assert property (
		(s.bus.address_valid && s.is_burst) |-> s.bus.burst_indicator)
		else $error("burst indicator missing on burst address");

	a_first_strobe_start: assert property (
		($rose(s.bus.address_valid) && s.is_burst)
		|-> s.bus.first_of_burst_strobe && s.bus.bus_word_address[1:0] == s.start_word)
		else $error("first strobe not with first address");

	a_last_strobe_fourth: assert property (
		s.bus.last_of_burst_strobe |-> s.bus.burst_indicator && s.addr_cnt == WORD_LAST)
		else $error("last strobe not with fourth address");

	a_seq_order_step: assert property (
		(s.bus.address_valid && address_accept_ready_in && s.is_burst && !s.sub_order
			&& s.addr_cnt != WORD_LAST)
		|=> s.bus.bus_word_address[1:0] == 2'($past(s.bus.bus_word_address[1:0]) + 2'h1))
		else $error("sequential order step wrong");

	a_sub_order_step: assert property (
		(s.bus.address_valid && address_accept_ready_in && s.is_burst && s.sub_order
			&& s.addr_cnt != WORD_LAST)
		|=> s.bus.bus_word_address[1:0] == (s.start_word ^ 2'($past(s.addr_cnt) + 2'h1)))
		else $error("sub-block order step wrong");

	a_read_sample_gap: assert property (
		(s.state == BBT_ST_RUN && !s.is_write && s.bus.address_valid && address_accept_ready_in
			&& s.addr_cnt == WORD_FIRST)
		|=> !s.rd_open ##1 s.rd_open)
		else $error("read sampling did not open two clocks after ready");

	a_read_capture: assert property (
		(s.rd_open && read_data_valid_in)
		|=> rd_ret_out.valid && rd_ret_out.data == $past(read_data_bus_in))
		else $error("read word not captured");

	a_read_four_words: assert property (
		(s.rd_open && read_data_valid_in && s.data_cnt == WORD_LAST) |=> !s.rd_open && s.data_done)
		else $error("read burst did not end after four words");

	a_write_full_burst: assert property (
		($rose(s.bus.address_valid) && s.bus.write_indicator && s.bus.burst_indicator)
		|-> s.pend_mask == MASK_FULL)
		else $error("burst write from partial entry");

	a_write_start_zero: assert property (
		(s.bus.first_of_burst_strobe && s.bus.write_indicator)
		|-> s.bus.bus_word_address[1:0] == WORD_FIRST)
		else $error("burst write did not start at word zero");

	a_write_flags_addr: assert property (
		(s.bus.burst_indicator && s.is_write) |-> s.bus.write_indicator && s.bus.address_valid)
		else $error("write burst flags missing");

	a_wdata_hold_wait: assert property (
		(s.is_write && !s.data_done && !s.wd_need && !write_data_ready_in && s.state == BBT_ST_RUN)
		|=> $stable(write_data_bus_out))
		else $error("write word changed without ready");

	a_read_write_low: assert property (
		(s.bus.address_valid && !s.is_write) |-> !s.bus.write_indicator)
		else $error("write indicator high on read");

	a_addr_at_launch: assert property (
		launch |=> s.bus.address_valid && s.bus.bus_word_address[1:0] == s.start_word)
		else $error("address not presented after request");

endmodule

// ### shared/bbt_pkg.sv
package bbt_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 34;
	localparam int BLOCK_W = 32;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int WORDS = 4;

	localparam logic [1:0] WORD_FIRST = 2'h0;
	localparam logic [1:0] WORD_LAST = 2'h3;
	localparam logic [3:0] BYTES_ALL = 4'hF;
	localparam logic [3:0] MASK_FULL = 4'hF;
	localparam logic [3:0] MASK_NONE = 4'h0;

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	// Read data is first sampled this many edges after the first accepted address
	localparam int RD_FIRST_SAMPLE = 2;
	localparam logic [1:0] RD_GAP = 2'(RD_FIRST_SAMPLE - 2);

	// ----------------------------------------------------------------
	// Write word buffer
	// ----------------------------------------------------------------
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL = 2'h2;
	localparam logic [1:0] BUF_EMPTY = 2'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BBT_ST_IDLE = 2'b01,
		BBT_ST_RUN = 2'b10
	} bbt_state_type;

	typedef struct packed {
		logic is_write;
		logic instr;
		logic [BLOCK_W-1:0] block;
		logic [1:0] crit_word;
		logic [WORDS-1:0] word_mask;
		logic [BE_W-1:0] byte_en;
	} bbt_req_type;

	typedef struct packed {
		logic [ADDR_W-1:0] bus_word_address;
		logic [BE_W-1:0] bus_byte_enables;
		logic address_valid;
		logic instruction_fetch_flag;
		logic burst_indicator;
		logic first_of_burst_strobe;
		logic last_of_burst_strobe;
		logic write_indicator;
	} bbt_bus_type;

	typedef struct packed {
		logic valid;
		logic err;
		logic [1:0] index;
		logic [DATA_W-1:0] data;
	} bbt_ret_type;

	// Word index of step idx within a block
	function automatic logic [1:0] bbt_order(input logic [1:0] start, input logic [1:0] idx,
		input logic sub);
		return sub ? (start ^ idx) : 2'(start + idx);
	endfunction

endpackage

// ### tb/bbt_bus_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far-side bus logic: paces addresses, returns reads, accepts writes
// ----------------------------------------------------------------
module bbt_bus_model (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic slow_in,
	input wire logic err_in,
	input wire bbt_pkg::bbt_bus_type bus_ctl_in,
	output logic address_accept_ready_out,
	output logic [bbt_pkg::DATA_W-1:0] read_data_bus_out,
	output logic read_data_valid_out,
	output logic read_bus_error_out,
	output logic write_data_ready_out,
	output logic write_bus_error_out
);
	import bbt_pkg::*;
	logic [ADDR_W-1:0] rq[$];
	int tq[$];
	int cyc = 0;
	int wpend = 0;
	// One process drives every output, so reset clears them here
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rq.delete();
			tq.delete();
			wpend = 0;
			{address_accept_ready_out, read_data_valid_out, read_bus_error_out} = 3'h0;
			{write_data_ready_out, write_bus_error_out} = 2'h0;
			read_data_bus_out = 32'h0;
		end else begin
			cyc++;
			if (read_data_valid_out) begin
				void'(rq.pop_front());
				void'(tq.pop_front());
			end
			if (bus_ctl_in.address_valid && address_accept_ready_out) begin
				if (bus_ctl_in.write_indicator) begin
					wpend++;
				end else begin
					rq.push_back(bus_ctl_in.bus_word_address);
					tq.push_back(cyc + 2);
				end
			end
			if (write_data_ready_out) begin
				wpend--;
			end
			#1;
			write_bus_error_out = err_in && write_data_ready_out;
			address_accept_ready_out = !slow_in || cyc[0];
			write_data_ready_out = wpend > 0 && (!slow_in || cyc[0]);
			read_data_valid_out = rq.size() > 0 && tq[0] <= cyc + 1 && (!slow_in || cyc[1]);
			read_bus_error_out = read_data_valid_out && err_in;
			// Idle data lines toggle so a stale word is never mistaken for a fresh one
			if (read_data_valid_out) begin
				read_data_bus_out = rq[0][31:0] ^ 32'h5A5A0000;
			end else begin
				read_data_bus_out = ~read_data_bus_out;
			end
		end
	end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	import bbt_pkg::*;
	localparam logic [31:0] BLK = 32'h0ABCDEF1;
	logic clock_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0, wr_valid_in = 1'b0;
	logic sub = 1'b0, slow = 1'b0, err = 1'b0;
	logic req_ready_out, wr_ready_out, wr_err_out, busy_out;
	logic ardy, rdval, rberr, wdrdy, wberr;
	logic [DATA_W-1:0] wr_word_in = 32'h0, write_data_bus_out, rdata;
	bbt_req_type req_in = '0;
	bbt_bus_type bus_ctl_out;
	bbt_ret_type rd_ret_out;
	bbt_bus_type aq[$];
	bbt_ret_type rq[$];
	logic [DATA_W-1:0] wq[$], dq[$];
	int n_errors = 0, samples_checked = 0, cycles = 0, n_werr = 0;

	bbt_engine dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
		.req_in(req_in), .req_ready_out(req_ready_out), .wr_valid_in(wr_valid_in),
		.wr_word_in(wr_word_in), .wr_ready_out(wr_ready_out), .bus_ctl_out(bus_ctl_out),
		.write_data_bus_out(write_data_bus_out), .address_accept_ready_in(ardy),
		.subblock_order_select_in(sub), .read_data_bus_in(rdata), .read_data_valid_in(rdval),
		.read_bus_error_in(rberr), .write_data_ready_in(wdrdy), .write_bus_error_in(wberr),
		.rd_ret_out(rd_ret_out), .wr_err_out(wr_err_out), .busy_out(busy_out));
	bbt_bus_model partner (.clock_in(clock_in), .rst_n_in(rst_n_in), .slow_in(slow),
		.err_in(err), .bus_ctl_in(bus_ctl_out), .address_accept_ready_out(ardy),
		.read_data_bus_out(rdata), .read_data_valid_out(rdval), .read_bus_error_out(rberr),
		.write_data_ready_out(wdrdy), .write_bus_error_out(wberr));

	initial begin
		forever #4 clock_in = ~clock_in;
	end

	// ----------------------------------------------------------------
	// Bus monitor and write word feeder
	// ----------------------------------------------------------------
	always @(posedge clock_in) begin
		cycles++;
		if (bus_ctl_out.address_valid && ardy) aq.push_back(bus_ctl_out);
		if (rd_ret_out.valid) rq.push_back(rd_ret_out);
		if (wdrdy) dq.push_back(write_data_bus_out);
		if (wr_err_out) n_werr++;
		if (wr_valid_in && wr_ready_out) void'(wq.pop_front());
		#1;
		wr_valid_in = wq.size() > 0;
		if (wq.size() > 0) wr_word_in = wq[0];
		if (cycles > 20000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hold the request until the engine reports busy, then wait for it to finish
	task automatic run(input logic wr, input logic ins, input logic [1:0] crit,
		input logic [3:0] m);
		int n = 0;
		aq.delete();
		rq.delete();
		dq.delete();
		n_werr = 0;
		req_in = '{is_write: wr, instr: ins, block: BLK, crit_word: crit, word_mask: m,
			byte_en: 4'h6};
		req_valid_in = 1'b1;
		while (busy_out !== 1'b1 && n < 50) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		check({busy_out, req_ready_out, bus_ctl_out.address_valid}, 3'h5);
		req_valid_in = 1'b0;
		while (busy_out !== 1'b0 && n < 200) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		repeat (4) @(posedge clock_in);
		#1;
		check({busy_out, req_ready_out, bus_ctl_out.address_valid}, 3'h2);
	endtask

	task automatic read_burst(input logic s, input logic [1:0] st, input logic ins,
		input logic e);
		logic [1:0] idx;
		sub = s;
		err = e;
		slow = st[0] ^ s;
		run(1'b0, ins, st, 4'h0);
		check(aq.size(), 4);
		check(rq.size(), 4);
		for (int i = 0; i < 4; i++) begin
			idx = s ? st ^ 2'(i) : st + 2'(i);
			check(aq[i].bus_word_address, {BLK, idx});
			check({aq[i].burst_indicator, aq[i].first_of_burst_strobe,
				aq[i].last_of_burst_strobe}, {1'b1, i == 0, i == 3});
			check({aq[i].write_indicator, aq[i].instruction_fetch_flag}, {1'b0, ins});
			check({rq[i].index, rq[i].err, rq[i].data},
				{idx, e, {BLK[29:0], idx} ^ 32'h5A5A0000});
		end
	endtask

	task automatic write_txn(input logic [3:0] m, input logic st, input logic e);
		int k = 0;
		slow = st;
		err = e;
		for (int i = 0; i < 4; i++) begin
			if (m[i]) wq.push_back(32'hC0DE0000 + i);
		end
		run(1'b1, 1'b1, 2'h2, m);
		for (int i = 0; i < 4; i++) begin
			if (m[i]) begin
				check(aq[k].bus_word_address, {BLK, 2'(i)});
				check({aq[k].write_indicator, aq[k].burst_indicator,
					aq[k].instruction_fetch_flag}, {1'b1, m == 4'hF, 1'b0});
				check({aq[k].first_of_burst_strobe, aq[k].last_of_burst_strobe},
					{m == 4'hF && k == 0, m == 4'hF && k == 3});
				check(aq[k].bus_byte_enables, m == 4'hF ? BYTES_ALL : 4'h6);
				check(dq[k], 32'hC0DE0000 + i);
				k++;
			end
		end
		check(aq.size(), k);
		check(dq.size(), k);
		check(n_werr, e ? k : 0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		repeat (2) @(posedge clock_in);
		#1;
		for (int s = 0; s < 2; s++) begin
			for (int st = 0; st < 4; st++) begin
				read_burst(s[0], st[1:0], st[0], 1'b0);
			end
		end
		read_burst(1'b1, 2'h2, 1'b1, 1'b1);
		write_txn(4'hF, 1'b0, 1'b0);
		write_txn(4'hF, 1'b1, 1'b1);
		write_txn(4'h5, 1'b0, 1'b0);
		write_txn(4'hA, 1'b1, 1'b1);
		finish_test();
	end
endmodule
